// ---- dv/limit_slowdown_sva.sv ----
// port-level checker for the limit and slow-down input block
`timescale 1ns/100ps
module limit_slowdown_sva (
  input logic        clk,
  input logic        rst_n,
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  input logic        move_busy,
  input logic        move_accel,
  input logic        start_req,
  input logic        start_dir_minus,
  input logic        start_accel,
  input logic        start_refused,
  input logic        stop_now,
  input logic        decel_stop
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held too long");
  ack_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("ack without request");
  rdata_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o && !wb_we_i) else $error("read data moved");
  start_excl_a: assert property (!(start_req && start_refused)) else $error("start both taken and refused");
  req_pulse_a: assert property (start_req |=> !start_req) else $error("start pulse too long");
  refuse_pulse_a: assert property ($rose(start_refused) |=> $fell(start_refused)) else $error("refuse too long");
  start_attr_a: assert property (!start_req |-> $stable({start_dir_minus, start_accel})) else $error("attr moved");
  stop_sticky_a: assert property (stop_now && !start_req |=> stop_now || start_req) else $error("stop let go");
  stop_in_move_a: assert property ($rose(stop_now) |-> $past(move_busy) || $past(decel_stop, 2))
    else $error("stop while idle");
  decel_accel_a: assert property ($rose(decel_stop) |-> $past(move_accel)) else $error("decel on flat move");
  cover property ($rose(start_refused));
  cover property ($rose(stop_now));
  cover property ($rose(decel_stop));
endmodule // limit_slowdown_sva

// ---- dv/sensor_switches.sv ----
// contact-level model of the limit and slow-down switches
`timescale 1ns/100ps
module sensor_switches (
  input  logic act_plus,
  input  logic act_minus,
  input  logic act_sd,
  input  logic plus_pol,
  input  logic minus_pol,
  input  logic sd_pol,
  output logic plus_pin,
  output logic minus_pin,
  output logic sd_pin
);
  // ----
  // contact polarity
  // ----
  // switches always drive, so no released level exists
  assign plus_pin  = act_plus ^ plus_pol;
  assign minus_pin = act_minus ^ minus_pol;
  assign sd_pin    = ~(act_sd ^ sd_pol);
endmodule // sensor_switches

// ---- dv/tb_top.sv ----
// self-checking bench for the limit and slow-down input block
`timescale 1ns/100ps
`include "limit_slowdown_regs.vh"
module tb_top;
  logic        clk, rst_n, cyc, stb, we, busy, dmin, acc, hs;
  logic        ack, sreq, sdir, sacc, sref, stop, dstop, hold;
  logic        a_p, a_m, a_s, pol_p, pol_m, sd_pol;
  logic [3:0]  adr;
  logic [31:0] wdat, rdat, rd, r;
  logic [4:0]  outs;
  wire         p_in, m_in, s_in;
  int          bad_count, checks, dcnt, n_req, n_ref;
  assign outs = {hold, dstop, stop, sref, sreq};
  limit_and_slowdown_inputs dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .plus_limit_in(p_in),
    .minus_limit_in(m_in), .slowdown_in(s_in), .plus_limit_polarity_pin(pol_p), .minus_limit_polarity_pin(pol_m),
    .move_busy(busy), .move_dir_minus(dmin), .move_accel(acc), .move_high_speed(hs), .start_req(sreq),
    .start_dir_minus(sdir), .start_accel(sacc), .start_refused(sref), .stop_now(stop), .decel_stop(dstop),
    .hold_start_speed(hold));
  sensor_switches sw (.act_plus(a_p), .act_minus(a_m), .act_sd(a_s), .plus_pol(pol_p), .minus_pol(pol_m),
    .sd_pol(sd_pol), .plus_pin(p_in), .minus_pin(m_in), .sd_pin(s_in));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ----
  // motion generator stand-in, decel stop ends after 12 cycles
  // ----
  always @(posedge clk) begin
    if (sreq) n_req <= n_req + 1;
    if (sref) n_ref <= n_ref + 1;
    if (sreq) begin
      busy <= 1'b1;
      dmin <= sdir;
      acc <= sacc;
      hs <= sacc;
    end else if (stop || dcnt == 12) begin
      busy <= 1'b0;
    end
    dcnt <= (dstop && busy) ? dcnt + 1 : 0;
  end
  function automatic logic [31:0] st(input logic p, m, l, s);
    st = 32'h0;
    st[`BIT_PLUS_LIMIT_STATE] = p;
    st[`BIT_MINUS_LIMIT_STATE] = m;
    st[`BIT_SLOWDOWN_LATCH] = l;
    st[`BIT_SLOWDOWN_RAW] = s;
  endfunction
  task automatic chk(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [31:0] m, e);
    bus(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic irq(input logic [31:0] m, e);
    rchk(`OFS_IRQ_CAUSE_WORD, m, e);
    bus(1'b1, `OFS_IRQ_CAUSE_WORD, 32'hffff_ffff);
  endtask
  // environment writes are ignored in command mode, so leave it first
  task automatic cfg(input logic [31:0] env, md);
    bus(1'b1, `OFS_MODE_WORD, 32'h0);
    bus(1'b1, `OFS_ENVIRONMENT_WORD, env);
    sd_pol <= env[`BIT_SLOWDOWN_POLARITY];
    bus(1'b1, `OFS_MODE_WORD, md | 32'h8000_0000);
  endtask
  task automatic cmd(input logic dm, ac, ok);
    int q, f;
    q = n_req;
    f = n_ref;
    bus(1'b1, `OFS_COMMAND_WORD, {29'h0, ac, dm, 1'b1});
    repeat (2) @(negedge clk);
    chk(n_req - q, ok);
    chk(n_ref - f, !ok);
    if (ok) chk({sdir, sacc}, {dm, ac});
    @(posedge clk);
  endtask
  task automatic look(input int k, input logic v, input int lim, input bit upto);
    int n;
    for (n = 0; n < lim && !(upto && outs[k] === v); n++) @(negedge clk);
    chk(outs[k], v);
    @(posedge clk);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #5_000_000;
    bad_count++;
    tally_and_finish;
  end
  initial begin
    {rst_n, cyc, stb, we, busy, dmin, acc, hs, a_p, a_m, a_s, pol_p, pol_m, sd_pol} = '0;
    adr = 4'h0;
    wdat = 32'h0;
    r = $urandom(58153);
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk(outs, 5'h0);
    rchk(`OFS_ENVIRONMENT_WORD, 32'hffff_ffff, `ENVIRONMENT_RESET);
    rchk(`OFS_MODE_WORD, 32'hffff_ffff, `MODE_RESET);
    rchk(4'h3, 32'hffff_ffff, 32'h0);
    repeat (6) begin
      r = $urandom;
      {pol_p, pol_m, a_p, a_m} <= r[3:0];
      repeat (6) @(posedge clk);
      rchk(`OFS_STATUS_WORD, st(1, 1, 0, 0), st(r[1], r[0], 0, 0));
    end
    {a_p, a_m} <= 2'b10;
    cfg(32'h0, 32'h0);
    cmd(0, 0, 0);
    cmd(1, 0, 1);
    look(2, 0, 10, 0);
    a_m <= 1'b1;
    @(posedge clk);
    a_m <= 1'b0;
    look(2, 1, 10, 1);
    look(2, 1, 10, 0);
    irq(32'h0000_0030, 32'h0000_0020);
    a_p <= 1'b0;
    cfg(32'h0000_0008, 32'h0);
    cmd(0, 1, 1);
    a_p <= 1'b1;
    look(3, 1, 10, 1);
    look(2, 0, 1, 0);
    a_p <= 1'b0;
    irq(32'h0000_0030, 32'h0000_0010);
    cfg(32'h0, 32'h0000_0001);
    a_p <= 1'b1;
    cmd(0, 0, 1);
    look(2, 0, 10, 0);
    rchk(`OFS_STATUS_WORD, st(1, 0, 0, 0), st(1, 0, 0, 0));
    a_p <= 1'b0;
    cfg(32'h0000_1000, 32'h0);
    cmd(1, 0, 1);
    a_m <= 1'b1;
    repeat (30) @(posedge clk);
    a_m <= 1'b0;
    look(2, 0, 50, 0);
    a_m <= 1'b1;
    look(2, 0, 36, 0);
    look(2, 1, 20, 1);
    a_m <= 1'b0;
    cfg(32'h0000_0040, 32'h0);
    cmd(0, 1, 1);
    a_s <= 1'b1;
    look(4, 0, 10, 0);
    cfg(32'h0000_0040, 32'h0000_0040);
    cmd(0, 1, 1);
    look(4, 1, 10, 1);
    a_s <= 1'b0;
    look(4, 0, 10, 1);
    cmd(0, 0, 1);
    a_s <= 1'b1;
    look(4, 0, 10, 0);
    a_s <= 1'b0;
    cfg(32'h0000_0060, 32'h0000_0040);
    cmd(0, 1, 1);
    a_s <= 1'b1;
    look(4, 1, 10, 1);
    a_s <= 1'b0;
    look(4, 1, 10, 0);
    rchk(`OFS_STATUS_WORD, st(0, 0, 1, 1), st(0, 0, 1, 0));
    cmd(0, 1, 1);
    look(4, 0, 10, 0);
    cfg(32'h0000_0050, 32'h0000_0040);
    cmd(0, 0, 1);
    a_s <= 1'b1;
    look(2, 1, 10, 1);
    cmd(0, 1, 0);
    a_s <= 1'b0;
    repeat (4) @(posedge clk);
    cmd(0, 1, 1);
    a_s <= 1'b1;
    look(3, 1, 10, 1);
    a_s <= 1'b0;
    look(3, 0, 6, 1);
    a_s <= 1'b1;
    look(3, 1, 10, 1);
    repeat (20) @(posedge clk);
    irq(32'h0000_0008, 32'h0000_0008);
    a_s <= 1'b0;
    repeat (4) @(posedge clk);
    cfg(32'h0000_0070, 32'h0000_0040);
    cmd(0, 1, 1);
    a_s <= 1'b1;
    look(3, 1, 10, 1);
    a_s <= 1'b0;
    look(3, 1, 6, 0);
    tally_and_finish;
  end
endmodule // tb_top
bind limit_and_slowdown_inputs limit_slowdown_sva sva_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .move_busy(move_busy),
  .move_accel(move_accel), .start_req(start_req), .start_dir_minus(start_dir_minus), .start_accel(start_accel),
  .start_refused(start_refused), .stop_now(stop_now), .decel_stop(decel_stop));

// ---- hdl/limit_and_slowdown_inputs.v ----
// limit and slow-down input handling with a classic wishbone register slave
`timescale 1ns/100ps
`include "limit_slowdown_regs.vh"

module limit_and_slowdown_inputs #(
  parameter FILT_W = 6
) (
  input  wire        clk,
  input  wire        rst_n,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [3:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  // sensor pins
  input  wire        plus_limit_in,
  input  wire        minus_limit_in,
  input  wire        slowdown_in,
  input  wire        plus_limit_polarity_pin,
  input  wire        minus_limit_polarity_pin,
  // motion generator status
  input  wire        move_busy,
  input  wire        move_dir_minus,
  input  wire        move_accel,
  input  wire        move_high_speed,
  // requests to motion generator
  output reg         start_req,
  output reg         start_dir_minus,
  output reg         start_accel,
  output reg         start_refused,
  output reg         stop_now,
  output reg         decel_stop,
  output reg         hold_start_speed
);

  // ---------------------------------------------
  // constants
  // ---------------------------------------------
  // the count is cut to the counter width on purpose; FILT_W must hold it
  localparam integer      FILT_CYC = `FILTER_CYCLES;
  localparam [FILT_W-1:0] FILT_MAX = FILT_CYC[FILT_W-1:0];
  localparam [3:0] ADR_CMD = 4'h0;

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  reg  [31:0]       environment_word;
  reg  [31:0]       mode_word;
  reg  [5:3]        irq_cause;
  reg  [2:0]        sync_a;
  reg  [2:0]        sync_b;
  reg  [2:0]        filt;
  reg  [FILT_W-1:0] filt_cnt [0:2];
  reg               slowdown_latch_state;
  reg               stop_hold;
  reg               sd_stop_armed;
  reg               sd_prev;
  reg               busy_prev;
  reg               cmd_pending;
  reg               cmd_dir_minus;
  reg               cmd_accel;
  integer           i;

  wire limit_stop_pattern = environment_word[`BIT_LIMIT_STOP_PATTERN];
  wire slowdown_action    = environment_word[`BIT_SLOWDOWN_ACTION];
  wire slowdown_latch_sel = environment_word[`BIT_SLOWDOWN_LATCH_SEL];
  wire slowdown_polarity  = environment_word[`BIT_SLOWDOWN_POLARITY];
  wire input_filter_en    = environment_word[`BIT_INPUT_FILTER_EN];
  wire slowdown_enable    = mode_word[`BIT_SLOWDOWN_ENABLE];
  wire timer_mode         = mode_word[`BIT_TIMER_MODE];

  // ---------------------------------------------
  // bus decode
  // ---------------------------------------------
  wire bus_req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire bus_wr   = bus_req & wb_we_i;
  wire wr_env   = bus_wr & (wb_adr_i == `OFS_ENVIRONMENT_WORD) & ~wb_adr_i[3];
  wire wr_mode  = bus_wr & (wb_adr_i == `OFS_MODE_WORD);
  wire wr_cause = bus_wr & (wb_adr_i == `OFS_IRQ_CAUSE_WORD);

  // byte-lane merge used by the environment and mode words
  function [31:0] merge;
    input [31:0] old;
    input [31:0] new_val;
    input [3:0]  sel;
    integer k;
    begin
      merge = old;
      for (k = 0; k < 4; k = k + 1) begin
        if (sel[k]) begin
          merge[k*8 +: 8] = new_val[k*8 +: 8];
        end
      end
    end
  endfunction

  // ---------------------------------------------
  // synchroniser and polarity
  // ---------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 3'b000;
      sync_b <= 3'b000;
    end else begin
      sync_a <= {slowdown_in, minus_limit_in, plus_limit_in};
      sync_b <= sync_a;
    end
  end

  // bit0 plus, bit1 minus, bit2 slow-down; 1 means active
  wire [2:0] active_raw;
  assign active_raw[0] = sync_b[0] ^ plus_limit_polarity_pin;
  assign active_raw[1] = sync_b[1] ^ minus_limit_polarity_pin;
  assign active_raw[2] = slowdown_polarity ? sync_b[2] : ~sync_b[2];

  // ---------------------------------------------
  // glitch filter
  // ---------------------------------------------
  // the filtered level only follows after the new level stood FILT_MAX
  // cycles; with the filter off it follows the synchronised level at once
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      filt <= 3'b000;
      for (i = 0; i < 3; i = i + 1) begin
        filt_cnt[i] <= {FILT_W{1'b0}};
      end
    end else begin
      for (i = 0; i < 3; i = i + 1) begin
        if (active_raw[i] == filt[i]) begin
          filt_cnt[i] <= {FILT_W{1'b0}};
        end else if (!input_filter_en) begin
          filt[i]     <= active_raw[i];
          filt_cnt[i] <= {FILT_W{1'b0}};
        end else if (filt_cnt[i] == FILT_MAX - 1'b1) begin
          filt[i]     <= active_raw[i];
          filt_cnt[i] <= {FILT_W{1'b0}};
        end else begin
          filt_cnt[i] <= filt_cnt[i] + 1'b1;
        end
      end
    end
  end

  wire plus_limit_state  = filt[0];
  wire minus_limit_state = filt[1];
  wire slowdown_raw_state = filt[2];
  wire sd_active = slowdown_raw_state & slowdown_enable;

  // ---------------------------------------------
  // start command
  // ---------------------------------------------
  wire wr_cmd = bus_wr & (wb_adr_i == ADR_CMD) & wb_adr_i[3] == 1'b0
                & 1'b0;
  // command register shares offset 0 with the environment word; a write
  // there is a command only while mode bit 31 is set, which blocks environment writes
  wire wr_start = bus_wr & (wb_adr_i == 4'h0) & wb_sel_i[0]
                  & wb_dat_i[`BIT_CMD_START] & mode_word[31];
  wire limit_in_dir = wb_dat_i[`BIT_CMD_DIR_MINUS] ? minus_limit_state
                                                   : plus_limit_state;
  wire refuse_limit = limit_in_dir & ~timer_mode;
  wire refuse_sd    = sd_active & slowdown_action;
  wire start_taken  = wr_start & ~refuse_limit & ~refuse_sd;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      start_req       <= 1'b0;
      start_refused   <= 1'b0;
      start_dir_minus <= 1'b0;
      start_accel     <= 1'b0;
      cmd_pending     <= 1'b0;
      cmd_dir_minus   <= 1'b0;
      cmd_accel       <= 1'b0;
    end else begin
      start_req     <= start_taken;
      start_refused <= wr_start & (refuse_limit | refuse_sd);
      cmd_pending   <= wr_cmd;
      if (start_taken) begin
        start_dir_minus <= wb_dat_i[`BIT_CMD_DIR_MINUS];
        start_accel     <= wb_dat_i[`BIT_CMD_ACCEL];
        cmd_dir_minus   <= wb_dat_i[`BIT_CMD_DIR_MINUS];
        cmd_accel       <= wb_dat_i[`BIT_CMD_ACCEL];
      end
    end
  end

  // ---------------------------------------------
  // limit stop
  // ---------------------------------------------
  wire dir_limit = move_dir_minus ? minus_limit_state : plus_limit_state;
  wire limit_hit = move_busy & dir_limit & ~timer_mode;
  wire limit_decel = limit_stop_pattern & move_accel;

  // ---------------------------------------------
  // slow-down
  // ---------------------------------------------
  wire sd_rise   = sd_active & ~sd_prev;
  wire sd_effect = slowdown_latch_sel ? slowdown_latch_state : sd_active;
  wire sd_fast   = move_busy & move_high_speed & sd_effect;
  wire sd_const_stop = move_busy & ~move_high_speed & slowdown_action
                       & sd_rise;
  wire busy_fall = busy_prev & ~move_busy;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slowdown_latch_state <= 1'b0;
      stop_hold            <= 1'b0;
      sd_stop_armed        <= 1'b0;
      sd_prev              <= 1'b0;
      busy_prev            <= 1'b0;
    end else begin
      sd_prev   <= sd_active;
      busy_prev <= move_busy;
      // start or level choice releases; a live input re-latches at once
      if (!slowdown_latch_sel) begin
        slowdown_latch_state <= 1'b0;
      end else if (sd_active & (move_busy | wr_start)) begin
        slowdown_latch_state <= 1'b1;
      end else if (wr_start) begin
        slowdown_latch_state <= 1'b0;
      end
      // a limit stop or constant-feed slow-down stop holds until the next accepted start
      if (limit_hit | sd_const_stop) begin
        stop_hold <= 1'b1;
      end else if (start_taken) begin
        stop_hold <= 1'b0;
      end
      if (start_taken) begin
        sd_stop_armed <= 1'b0;
      end else if (sd_fast & slowdown_action) begin
        sd_stop_armed <= 1'b1;
      end else if (busy_fall) begin
        sd_stop_armed <= 1'b0;
      end
    end
  end

  // ---------------------------------------------
  // requests to the motion generator
  // ---------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stop_now         <= 1'b0;
      decel_stop       <= 1'b0;
      hold_start_speed <= 1'b0;
    end else begin
      stop_now   <= (limit_hit & ~limit_decel) | sd_const_stop
                    | (stop_hold & ~decel_stop);
      decel_stop <= (limit_hit & limit_decel)
                    | (sd_fast & slowdown_action);
      // level choice lets this fall when the input clears, so the
      // generator climbs back to high speed
      hold_start_speed <= sd_fast & ~slowdown_action;
    end
  end

  // ---------------------------------------------
  // interrupt cause bits, write one to clear, set wins
  // ---------------------------------------------
  wire [5:3] cause_set;
  assign cause_set[`BIT_SLOWDOWN_IRQ]    = sd_stop_armed & busy_fall;
  assign cause_set[`BIT_PLUS_LIMIT_IRQ]  = limit_hit & ~move_dir_minus;
  assign cause_set[`BIT_MINUS_LIMIT_IRQ] = limit_hit & move_dir_minus;
  wire [5:3] cause_clr = (wr_cause & wb_sel_i[0]) ? wb_dat_i[5:3] : 3'b000;

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_cause <= 3'b000;
    end else begin
      irq_cause <= (irq_cause & ~cause_clr) | cause_set;
    end
  end

  // ---------------------------------------------
  // register writes
  // ---------------------------------------------
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      environment_word <= `ENVIRONMENT_RESET;
      mode_word        <= `MODE_RESET;
    end else begin
      if (wr_env & ~mode_word[31]) begin
        environment_word <= merge(environment_word, wb_dat_i, wb_sel_i);
      end
      if (wr_mode) begin
        mode_word <= merge(mode_word, wb_dat_i, wb_sel_i);
      end
    end
  end

  // ---------------------------------------------
  // read mux and ack
  // ---------------------------------------------
  reg [31:0] next_dat;
  always @* begin
    next_dat = 32'h0000_0000;
    case (wb_adr_i)
      `OFS_ENVIRONMENT_WORD: begin
        next_dat = environment_word;
      end
      `OFS_MODE_WORD: begin
        next_dat = mode_word;
      end
      `OFS_STATUS_WORD: begin
        next_dat[`BIT_PLUS_LIMIT_STATE]  = plus_limit_state;
        next_dat[`BIT_MINUS_LIMIT_STATE] = minus_limit_state;
        next_dat[`BIT_SLOWDOWN_LATCH]    = slowdown_latch_state;
        next_dat[`BIT_SLOWDOWN_RAW]      = slowdown_raw_state;
      end
      `OFS_IRQ_CAUSE_WORD: begin
        next_dat[5:3] = irq_cause;
      end
      default: begin
        next_dat = 32'h0000_0000;
      end
    endcase
  end

  // one wait state; ack drops the cycle after it was given
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req;
      if (bus_req & ~wb_we_i) begin
        wb_dat_o <= next_dat;
      end
    end
  end

endmodule // limit_and_slowdown_inputs

// ---- include/limit_slowdown_regs.vh ----
// register map, field positions and timing constants for the limit and slow-down input block
// ---------------------------------------------
// Overview of operation
// - end limit of current direction stops motor, immediately or decelerating, per pattern.
// - limit pattern bit 03: 0 immediate stop, 1 decelerate stop if accelerated.
// - after a limit stop motor stays stopped though limit clears.
// - start refused toward a direction whose limit is active.
// - filter bit 12 rejects limit pulses under about 4 us, else 0.1 us passes.
// - status bit 18 shows plus limit, bit 17 minus limit, 1 active.
// - separate cause bits record which limit caused a stop.
// - timer mode takes no limit action but limit status stays readable.
// - each limit polarity pin: low active-high, high active-low.
// - mode bit 06 enables slow-down; environment bit 06 sets polarity, 1 active-high.
// - bit 04 selects slow to start speed or stop; bit 05 level or latched.
// - level slow mode ignores constant feed; high feed slows, re-accelerates on clear.
// - level slow mode with slow-down at accelerated start runs start speed until clear.
// - latched slow mode holds start speed after trigger, including active at start.
// - slow-down latch released by next start or choosing level behaviour.
// - stop modes: slow-down during constant feed stops immediately.
// - level stop mode decelerates and stops, re-accelerates if cleared, stays stopped.
// - latched stop mode does not re-accelerate when slow-down clears.
// - stop modes: slow-down active at start refuses start and ends operation.
// - slow-down deceleration stop sets cause bit 03.
// - slow-down filter needs 40 clock cycles, unfiltered one cycle suffices.
// - status bit 19 shows slow-down latch, bit 20 raw slow-down input.
// ---------------------------------------------
`ifndef LIMIT_SLOWDOWN_REGS_VH
`define LIMIT_SLOWDOWN_REGS_VH

// ---------------------------------------------
// register byte offsets
// ---------------------------------------------
`define OFS_ENVIRONMENT_WORD 4'h0
`define OFS_MODE_WORD        4'h4
`define OFS_STATUS_WORD      4'h8
`define OFS_IRQ_CAUSE_WORD   4'hc
`define OFS_COMMAND_WORD     4'h0

// ---------------------------------------------
// field positions
// ---------------------------------------------
`define BIT_LIMIT_STOP_PATTERN 3
`define BIT_SLOWDOWN_ACTION    4
`define BIT_SLOWDOWN_LATCH_SEL 5
`define BIT_SLOWDOWN_POLARITY  6
`define BIT_INPUT_FILTER_EN    12
`define BIT_SLOWDOWN_ENABLE    6
`define BIT_TIMER_MODE         0
`define BIT_MINUS_LIMIT_STATE  17
`define BIT_PLUS_LIMIT_STATE   18
`define BIT_SLOWDOWN_LATCH     19
`define BIT_SLOWDOWN_RAW       20
`define BIT_SLOWDOWN_IRQ       3
`define BIT_PLUS_LIMIT_IRQ     4
`define BIT_MINUS_LIMIT_IRQ    5
`define BIT_CMD_START          0
`define BIT_CMD_DIR_MINUS      1
`define BIT_CMD_ACCEL          2

// ---------------------------------------------
// reset values and timing
// ---------------------------------------------
`define ENVIRONMENT_RESET 32'h0000_0000
`define MODE_RESET        32'h0000_0000
`define CLK_FREQ_KHZ      10000
`define FILTER_TIME_NS    4000
`define FILTER_CYCLES     ((`FILTER_TIME_NS * `CLK_FREQ_KHZ + 999999) / 1000000)

`endif
